// ==== verilog/switch_channel_consts.vh ====
// Purpose: constants for the switch channel state control block
// Assumes: included by bare name
// Notes: offsets are byte addresses on the apb bus
`ifndef SWITCH_CHANNEL_CONSTS_VH
`define SWITCH_CHANNEL_CONSTS_VH

`define NUM_CHANNELS 48
`define BANK_SIZE 24
`define CH_ISOLATION 7'd90
`define CH_TREE_SOURCE 7'd91
`define CH_TREE_SENSE 7'd92
`define CH_TREE_BOTH 7'd93

`define STATE_OPEN 3'd0
`define STATE_CLOSED 3'd1
`define STATE_SENSE 3'd2
`define STATE_SOURCE 3'd3
`define STATE_BOTH 3'd4

`define CMD_OPEN 2'd0
`define CMD_CLOSE 2'd1
`define CMD_RESET 2'd2
`define CMD_ADVANCE 2'd3

`define OFF_COMMAND 12'h000
`define OFF_QUERY 12'h004
`define OFF_STATE 12'h008
`define OFF_IDENT_LO 12'h00C
`define OFF_IDENT_HI 12'h010
`define OFF_STATUS 12'h014
`define OFF_SCAN_FIRST 12'h018
`define OFF_SCAN_LAST 12'h01C
`define OFF_BANK_A 12'h020
`define OFF_BANK_B 12'h024

`define CMD_CODE_LSB 8
`define STATUS_TRIP_BIT 0
`define STATUS_SCAN_BIT 1
`define STATUS_MODULE_BIT 2
`define STATUS_ISO_BIT 3

`endif

// ==== verilog/pin_sync.v ====
// Purpose: three stage synchroniser with agreement filter
// Assumes: async input, pclk domain
// Notes: output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter RESET_VALUE = 1'b0
) (
    input wire pclk,
    input wire presetn,
    input wire pin,
    output reg level
);
    reg stage1;
    reg stage2;
    reg stage3;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            level <= RESET_VALUE;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/switch_channel_state_control.v ====
// Purpose: switch state control for a 48 input switching multiplexer
// Assumes: apb slave on pclk, 20 MHz; slot, module and overvoltage pins are async
// Notes: one cycle apb answer, pslverr on unmapped addresses
// Behaviour
// [R1] Channel 90 is the isolation relays, 91 source tree, 92 sense tree, 93 both trees.
// [R2] Channels 0 to 47 are individual switches of the high line only, low stays common.
// [R3] A state query returns 0 open, 1 closed, 2 sense, 3 source, 4 both buses.
// [R4] The isolation relay state is ignored when forming readback codes.
// [R5] Bus codes 2 to 4 are given only for channels 0 to 47; tree channels give 0 or 1.
// [R6] A reset command opens every bank switch, tree switch and the isolation relays.
// [R7] Identity gives the full code, a partial code without terminal module, zero if empty.
// [R8] The controller picks system or scanner mode; the ribbon link is outside this block.
// [R9] The controller chains no more than six, or eight in an extender, on one ribbon link.
// [R10] Monitor scan closes listed channels one at a time per advance and halts past the last.
// [R11] During scanning the old channel opens before the next one closes.
// [R12] A backplane overvoltage opens the isolation relays at once without a command.
// [R13] The 48 switches form two banks of 24, each bank with its own tree switches; here both banks share one tree_source and one tree_sense bit.
// [R14] Each switch bit holds until open, close, reset, scan advance or overvoltage trip changes it.
`timescale 1ns/100ps
`default_nettype none
`include "switch_channel_consts.vh"
module switch_channel_state_control #(
    parameter NUM_CHANNELS = `NUM_CHANNELS,
    parameter BANK_SIZE = `BANK_SIZE,
    parameter [23:0] IDENT_FULL = 24'h123456, // arbitrary value
    parameter [23:0] IDENT_PARTIAL = 24'h123FFF // arbitrary value
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire slot_occupied,
    input wire terminal_attached,
    input wire overvoltage,
    output wire [NUM_CHANNELS-1:0] bank_close,
    output wire [1:0] source_tree_close,
    output wire [1:0] sense_tree_close,
    output wire isolation_close,
    output wire scan_active
);
    // ----------------------------------------
    // switch state
    // ----------------------------------------
    reg [NUM_CHANNELS-1:0] bank;
    reg tree_source;
    reg tree_sense;
    reg iso;
    reg trip;
    reg scanning;
    reg scan_break;
    reg [6:0] scan_ch;
    reg [6:0] scan_first;
    reg [6:0] scan_last;
    reg [6:0] query_ch;
    wire occupied_s;
    wire attached_s;
    wire over_s;

    pin_sync #(.RESET_VALUE(1'b0)) sync_slot (
        .pclk(pclk),
        .presetn(presetn),
        .pin(slot_occupied),
        .level(occupied_s)
    );
    pin_sync #(.RESET_VALUE(1'b0)) sync_term (
        .pclk(pclk),
        .presetn(presetn),
        .pin(terminal_attached),
        .level(attached_s)
    );
    pin_sync #(.RESET_VALUE(1'b0)) sync_over (
        .pclk(pclk),
        .presetn(presetn),
        .pin(overvoltage),
        .level(over_s)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire mapped = (paddr == `OFF_COMMAND) || (paddr == `OFF_QUERY) ||
        (paddr == `OFF_STATE) || (paddr == `OFF_IDENT_LO) ||
        (paddr == `OFF_IDENT_HI) || (paddr == `OFF_STATUS) ||
        (paddr == `OFF_SCAN_FIRST) || (paddr == `OFF_SCAN_LAST) ||
        (paddr == `OFF_BANK_A) || (paddr == `OFF_BANK_B);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    wire cmd_wr = wr & (paddr == `OFF_COMMAND);
    wire [1:0] cmd = pwdata[`CMD_CODE_LSB+1:`CMD_CODE_LSB];
    wire [6:0] cmd_ch = pwdata[6:0];
    wire cmd_bank = cmd_wr && (cmd_ch < NUM_CHANNELS);
    wire [5:0] cmd_idx = cmd_ch[5:0];
    wire do_close = cmd_wr && (cmd == `CMD_CLOSE);
    wire do_open = cmd_wr && (cmd == `CMD_OPEN);
    wire do_reset = cmd_wr && (cmd == `CMD_RESET);
    wire do_adv = cmd_wr && (cmd == `CMD_ADVANCE);

    // ----------------------------------------
    // switch control
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank <= {NUM_CHANNELS{1'b0}};
            tree_source <= 1'b0;
            tree_sense <= 1'b0;
            iso <= 1'b0;
            scanning <= 1'b0;
            scan_break <= 1'b0;
            scan_ch <= 7'h00;
        end else if (do_reset) begin
            bank <= {NUM_CHANNELS{1'b0}}; // [R6]
            tree_source <= 1'b0; // [R6]
            tree_sense <= 1'b0; // [R6]
            iso <= 1'b0; // [R6]
            scanning <= 1'b0;
            scan_break <= 1'b0;
            scan_ch <= 7'h00;
        end else begin
            if (do_close || do_open) begin
                if (cmd_bank) begin
                    bank[cmd_idx] <= do_close; // [R2] [R14]
                end
                case (cmd_ch)
                    `CH_ISOLATION: iso <= do_close; // [R1]
                    `CH_TREE_SOURCE: tree_source <= do_close; // [R1]
                    `CH_TREE_SENSE: tree_sense <= do_close; // [R1]
                    `CH_TREE_BOTH: begin
                        tree_source <= do_close; // [R1]
                        tree_sense <= do_close;
                    end
                    default: ;
                endcase
            end
            if (do_adv && !scan_break) begin
                if (scanning && scan_ch < NUM_CHANNELS) begin
                    bank[scan_ch[5:0]] <= 1'b0; // [R11]
                end
                if (!scanning) begin
                    scan_ch <= scan_first; // [R10]
                    scanning <= (scan_first < NUM_CHANNELS);
                    scan_break <= (scan_first < NUM_CHANNELS);
                end else if (scan_ch >= scan_last) begin
                    scanning <= 1'b0; // [R10]
                end else begin
                    scan_ch <= scan_ch + 7'd1;
                    scan_break <= 1'b1; // [R11]
                end
            end else if (scan_break) begin
                bank[scan_ch[5:0]] <= 1'b1; // [R11]
                scan_break <= 1'b0;
            end
            if (over_s) begin
                iso <= 1'b0; // [R12]
            end
        end
    end

    // ----------------------------------------
    // trip flag and registers
    // ----------------------------------------
    wire status_wr = wr & (paddr == `OFF_STATUS);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip <= 1'b0;
            scan_first <= 7'h00;
            scan_last <= 7'h00;
            query_ch <= 7'h00;
        end else begin
            if (over_s) begin
                trip <= 1'b1;
            end else if (status_wr && pwdata[`STATUS_TRIP_BIT]) begin
                trip <= 1'b0;
            end
            if (wr && paddr == `OFF_SCAN_FIRST) begin
                scan_first <= pwdata[6:0];
            end
            if (wr && paddr == `OFF_SCAN_LAST) begin
                scan_last <= pwdata[6:0];
            end
            if (wr && paddr == `OFF_QUERY) begin
                query_ch <= pwdata[6:0];
            end
        end
    end

    // ----------------------------------------
    // state readback code
    // ----------------------------------------
    wire q_bank = query_ch < NUM_CHANNELS;
    wire q_upper = query_ch >= BANK_SIZE;
    wire [1:0] src_pair = {tree_source, tree_source};
    wire [1:0] sns_pair = {tree_sense, tree_sense};
    // both banks reach the backplane through the shared tree_source and tree_sense bits
    wire q_src = q_upper ? src_pair[1] : src_pair[0]; // [R13]
    wire q_sns = q_upper ? sns_pair[1] : sns_pair[0]; // [R13]
    reg [2:0] code;
    always @* begin
        code = `STATE_OPEN;
        if (q_bank) begin
            if (bank[query_ch[5:0]]) begin
                if (q_src && q_sns) begin
                    code = `STATE_BOTH; // [R3]
                end else if (q_src) begin
                    code = `STATE_SOURCE; // [R3]
                end else if (q_sns) begin
                    code = `STATE_SENSE; // [R3]
                end else begin
                    code = `STATE_CLOSED; // [R3]
                end
            end
        end else begin
            case (query_ch)
                `CH_TREE_SOURCE: code = {2'b00, tree_source}; // [R5]
                `CH_TREE_SENSE: code = {2'b00, tree_sense}; // [R5]
                `CH_TREE_BOTH: code = {2'b00, tree_source & tree_sense}; // [R5]
                default: code = `STATE_OPEN; // [R4]
            endcase
        end
    end

    // ----------------------------------------
    // identity
    // ----------------------------------------
    wire [23:0] ident = !occupied_s ? 24'h000000 :
        (attached_s ? IDENT_FULL : IDENT_PARTIAL); // [R7]

    // ----------------------------------------
    // read data
    // ----------------------------------------
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `OFF_QUERY: next_prdata = {25'h0000000, query_ch};
            `OFF_STATE: next_prdata = {29'h00000000, code};
            `OFF_IDENT_LO: next_prdata = {20'h00000, ident[11:0]};
            `OFF_IDENT_HI: next_prdata = {20'h00000, ident[23:12]};
            `OFF_STATUS: next_prdata = {28'h0000000, iso, attached_s, scanning, trip};
            `OFF_SCAN_FIRST: next_prdata = {25'h0000000, scan_first};
            `OFF_SCAN_LAST: next_prdata = {25'h0000000, scan_last};
            `OFF_BANK_A: next_prdata = {8'h00, bank[BANK_SIZE-1:0]};
            `OFF_BANK_B: next_prdata = {8'h00, bank[NUM_CHANNELS-1:BANK_SIZE]};
            default: next_prdata = 32'h00000000;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    assign bank_close = bank;
    assign source_tree_close = src_pair;
    assign sense_tree_close = sns_pair;
    assign isolation_close = iso;
    assign scan_active = scanning;
endmodule
`default_nettype wire

// ==== testbench/switch_channel_state_control_sva.sv ====
// Purpose: port assertions for the switch channel state control
// Assumes: bound to the design top, one pclk domain
// Notes: write effects land on the access edge
`timescale 1ns/100ps
`default_nettype none
module switch_channel_state_control_sva #(
    parameter NUM_CHANNELS = 48
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic overvoltage,
    input wire logic [NUM_CHANNELS-1:0] bank_close,
    input wire logic [1:0] source_tree_close,
    input wire logic [1:0] sense_tree_close,
    input wire logic isolation_close,
    input wire logic scan_active
);
    // ------------------------------
    // checks
    // ------------------------------
    wire logic wr = psel && penable && pwrite;
    wire logic cmd = wr && paddr == 12'h000;
    wire logic bank = pwdata[6:0] < 7'h30;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_reset_all;
        cmd && pwdata[9:8] == 2'h2 |=> !(|{bank_close, source_tree_close, sense_tree_close,
            isolation_close});
    endproperty
    a_reset_all: assert property (p_reset_all) else $error("switch left closed");
    property p_close_bank;
        cmd && pwdata[9:8] == 2'h1 && bank && !scan_active |=> bank_close[$past(pwdata[5:0])];
    endproperty
    a_close_bank: assert property (p_close_bank) else $error("bank not closed");
    property p_open_bank;
        cmd && pwdata[9:8] == 2'h0 && bank && !scan_active |=> !bank_close[$past(pwdata[5:0])];
    endproperty
    a_open_bank: assert property (p_open_bank) else $error("bank not opened");
    property p_hold;
        !wr && !$past(wr) && !scan_active && !$past(scan_active) |=> $stable(bank_close);
    endproperty
    a_hold: assert property (p_hold) else $error("bank moved unasked");
    property p_both_trees;
        cmd && pwdata[9:8] == 2'h1 && pwdata[6:0] == 7'h5D |=> (source_tree_close == 2'h3)
            && (sense_tree_close == 2'h3);
    endproperty
    a_both_trees: assert property (p_both_trees) else $error("tree pair not closed");
    property p_tree_pair;
        source_tree_close[0] == source_tree_close[1] && sense_tree_close[0] == sense_tree_close[1];
    endproperty
    a_tree_pair: assert property (p_tree_pair) else $error("bank trees differ");
    property p_trip;
        overvoltage [*6] |-> !isolation_close;
    endproperty
    a_trip: assert property (p_trip) else $error("isolation held through trip");
    property p_one_hot;
        scan_active |-> $countones(bank_close) <= 1;
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("two channels closed in scan");
    property p_code;
        psel && penable && !pwrite && paddr == 12'h008 |-> prdata <= 32'h4;
    endproperty
    a_code: assert property (p_code) else $error("state code out of range");
    c_scan: cover property (scan_active && $countones(bank_close) == 1);
    c_trip: cover property ($fell(isolation_close));
    c_err: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// ==== testbench/backplane_master.sv ====
// Purpose: apb master standing for the mainframe controller
// Assumes: slave may stretch the access phase
// Notes: one transfer per call
`timescale 1ns/100ps
`default_nettype none
module backplane_master (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // ------------------------------
    // transfers
    // ------------------------------
    // system mode, backplane only, one accessory on the link
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // advance requests come one at a time from here
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/switch_channel_state_control_bench.sv ====
// Purpose: self-checking bench for the switch channel state control
// Assumes: 20 MHz pclk, apb master model
// Notes: ident values are arbitrary
`timescale 1ns/100ps
`default_nettype none
module switch_channel_state_control_bench;
    localparam [23:0] ID_F = 24'hA5C3E1; // arbitrary value
    localparam [23:0] ID_P = 24'hA5CFFF; // arbitrary value
    logic pclk = 1'b0;
    logic presetn, slot_occupied, terminal_attached, overvoltage;
    logic psel, penable, pwrite, pready, pslverr, isolation_close, scan_active, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q_lo;
    logic [47:0] bank_close;
    logic [1:0] source_tree_close, sense_tree_close;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    backplane_master mst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    switch_channel_state_control #(.NUM_CHANNELS(48), .BANK_SIZE(24), .IDENT_FULL(ID_F),
        .IDENT_PARTIAL(ID_P)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slot_occupied(slot_occupied),
        .terminal_attached(terminal_attached), .overvoltage(overvoltage),
        .bank_close(bank_close), .source_tree_close(source_tree_close),
        .sense_tree_close(sense_tree_close), .isolation_close(isolation_close),
        .scan_active(scan_active));
    // ------------------------------
    // helpers
    // ------------------------------
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", n, x, s);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        mst.xfer(1'b1, a, d, q, e);
    endtask
    task rd(input logic [11:0] a);
        mst.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task cmd(input logic [1:0] c, input logic [6:0] ch);
        wr(12'h000, {22'h0, c, 1'b0, ch});
        @(negedge pclk);
    endtask
    task qry(input logic [6:0] ch, input logic [31:0] x);
        wr(12'h004, {25'h0, ch});
        rd(12'h008);
        chk("state", q, x);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task t_ident;
        for (int k = 0; k < 3; k++) begin
            slot_occupied <= k != 2;
            terminal_attached <= k == 0;
            repeat (6) @(posedge pclk);
            rd(12'h00C);
            q_lo = q;
            rd(12'h010);
            chk("ident", {q[11:0], q_lo[11:0]}, k == 0 ? ID_F : k == 1 ? ID_P : 24'h0);
        end
        slot_occupied <= 1'b1;
        terminal_attached <= 1'b1;
        $display("t_ident done");
    endtask
    task t_route;
        cmd(2'h1, 7'd3);
        cmd(2'h1, 7'd92);
        cmd(2'h1, 7'd90);
        cmd(2'h1, 7'd30);
        qry(7'd3, 32'h2);
        qry(7'd90, 32'h0);
        qry(7'd92, 32'h1);
        cmd(2'h1, 7'd93);
        qry(7'd30, 32'h4);
        qry(7'd93, 32'h1);
        cmd(2'h0, 7'd92);
        qry(7'd3, 32'h3);
        cmd(2'h0, 7'd91);
        qry(7'd3, 32'h1);
        qry(7'd4, 32'h0);
        cmd(2'h1, 7'd60);
        chk("count", $countones(bank_close), 32'h2);
        cmd(2'h0, 7'd3);
        chk("ch3", bank_close[3], 32'h0);
        $display("t_route done");
    endtask
    task t_reset;
        cmd(2'h2, 7'd0);
        chk("any", |{bank_close, source_tree_close, sense_tree_close, isolation_close}, 0);
        wr(12'h028, 32'h1);
        chk("err", e, 32'h1);
        $display("t_reset done");
    endtask
    task t_trip;
        cmd(2'h1, 7'd90);
        chk("iso", isolation_close, 32'h1);
        @(posedge pclk);
        overvoltage <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("iso", isolation_close, 32'h0);
        cmd(2'h1, 7'd90);
        chk("iso", isolation_close, 32'h0);
        @(posedge pclk);
        overvoltage <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(12'h014);
        chk("trip", q[0], 32'h1);
        wr(12'h014, 32'h1);
        rd(12'h014);
        chk("trip", q[0], 32'h0);
        $display("t_trip done");
    endtask
    task t_scan;
        wr(12'h018, 32'h5);
        wr(12'h01C, 32'h7);
        for (int i = 5; i < 9; i++) begin
            cmd(2'h3, 7'd0);
            @(negedge pclk);
            chk("scan", bank_close[31:0], i < 8 ? 32'h1 << i : 32'h0);
            chk("active", scan_active, i < 8);
        end
        $display("t_scan done");
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        presetn = 1'b0;
        slot_occupied = 1'b1;
        terminal_attached = 1'b1;
        overvoltage = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_ident;
        t_route;
        t_reset;
        t_trip;
        t_scan;
        tally_and_finish;
    end
endmodule
bind switch_channel_state_control switch_channel_state_control_sva #(
    .NUM_CHANNELS(NUM_CHANNELS)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .overvoltage(overvoltage), .bank_close(bank_close),
    .source_tree_close(source_tree_close), .sense_tree_close(sense_tree_close),
    .isolation_close(isolation_close), .scan_active(scan_active));
`default_nettype wire
